// ---- include/ser_pwr_pkg.sv ----
// constants shared by the serializer power and lock control block
package ser_pwr_pkg;

  // lock interval in parallel clock cycles
  localparam int unsigned LOCK_CYCLES     = 17100;
  localparam int unsigned LOCK_CNT_W      = 15;
  // bus register offsets
  localparam logic [3:0]  ADDR_CTRL       = 4'h0;
  localparam logic [3:0]  ADDR_STATUS     = 4'h4;
  localparam logic [3:0]  ADDR_LOCKCNT    = 4'h8;
  // control register field positions and reset value
  localparam int unsigned CTRL_PRE_BIT    = 0;
  localparam int unsigned CTRL_PRE_OVR    = 1;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  // two-bit range codes
  localparam logic [1:0]  RANGE_2M5_5M    = 2'h0;
  localparam logic [1:0]  RANGE_5M_10M    = 2'h1;
  localparam logic [1:0]  RANGE_10M_20M   = 2'h2;
  localparam logic [1:0]  RANGE_20M_42M   = 2'h3;
  // one-hot width of the decoded range
  localparam int unsigned RANGE_COUNT     = 4;

  // sequencer states
  typedef enum logic [1:0] {
    ST_DOWN,
    ST_LOCKING,
    ST_RUN
  } pwr_state_t;

endpackage : ser_pwr_pkg

// ---- verilog/lock_timer.sv ----
// counter that times the pll lock interval
`timescale 1ns/1ps
module lock_timer
  import ser_pwr_pkg::*;
#(
  parameter int unsigned COUNT = LOCK_CYCLES,
  parameter int unsigned W     = LOCK_CNT_W
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rstn_i,
  input  wire logic         clear_i,   // hold count at zero
  input  wire logic         run_i,     // advance count
  output logic [W-1:0]      count_o,
  output logic              done_o
);

  initial begin
    if (COUNT < 1 || COUNT >= (1 << W))
      $error("lock_timer: COUNT does not fit W");
  end

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         at_end;

  assign at_end  = (cnt_r == W'(COUNT));
  // saturate at the end so done stays high until cleared
  assign cnt_nxt = clear_i ? '0 :
                   (run_i && !at_end) ? cnt_r + W'(1) : cnt_r;

  // count register
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign count_o = cnt_r;
  assign done_o  = at_end;

endmodule : lock_timer

// ---- verilog/ser_power_ctrl.sv ----
// power-down, lock timing and range select control of the serializer
`timescale 1ns/1ps
module ser_power_ctrl
  import ser_pwr_pkg::*;
#(
  parameter int unsigned LOCK_COUNT = LOCK_CYCLES
) (
  input  wire logic        clk_sys_i,           // parallel input clock
  input  wire logic        rstn_i,
  input  wire logic        power_down_n_i,      // active-low power-down pin
  input  wire logic        freq_range_sel_lo_i,
  input  wire logic        freq_range_sel_hi_i,
  input  wire logic        preemph_en_i,        // preemphasis enable pin
  input  wire logic        input_buffer_supply_i, // high when supply good
  input  wire logic        serial_data_i,       // serial bit from the core
  input  wire logic        serial_edge_i,       // pulse on a bit transition
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             pll_run_o,           // pll enabled
  output logic             pll_locked_o,
  output logic             term_en_o,           // termination switched in
  output logic             out_p_o,
  output logic             out_n_o,
  output logic             out_oe_o,            // serial output driven
  output logic             preemph_pulse_o,     // extra current now
  output logic [RANGE_COUNT-1:0] range_onehot_o,
  output logic             sample_en_o          // capture data inputs
);

  initial begin
    if (LOCK_COUNT < 1 || LOCK_COUNT >= (1 << LOCK_CNT_W))
      $error("ser_power_ctrl: LOCK_COUNT out of range");
  end

  // ---- input qualification ----
  // with no input supply every single-ended input reads as low, except the raw power-down and preemphasis bits in status
  logic pd_eff_n;       // effective power-down, low means down
  logic pre_eff;        // effective preemphasis request
  logic [1:0] range_code;
  logic ctrl_pre_r;     // software preemphasis value
  logic ctrl_ovr_r;     // software overrides the pin

  assign pd_eff_n   = power_down_n_i & input_buffer_supply_i;
  assign range_code = input_buffer_supply_i ?
                      {freq_range_sel_hi_i, freq_range_sel_lo_i} : 2'h0;
  assign pre_eff    = ctrl_ovr_r ? ctrl_pre_r
                                 : (preemph_en_i & input_buffer_supply_i);

  // ---- range decode ----
  logic [RANGE_COUNT-1:0] range_dec;
  assign range_dec[0] = (range_code == RANGE_2M5_5M);
  assign range_dec[1] = (range_code == RANGE_5M_10M);
  assign range_dec[2] = (range_code == RANGE_10M_20M);
  assign range_dec[3] = (range_code == RANGE_20M_42M);

  // ---- sequencer ----
  pwr_state_t state_r;
  pwr_state_t state_nxt;
  logic       lock_done;
  logic [LOCK_CNT_W-1:0] lock_cnt;

  // power-down wins over every other condition
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_DOWN: begin
        if (pd_eff_n) state_nxt = ST_LOCKING;
      end
      ST_LOCKING: begin
        if (!pd_eff_n)     state_nxt = ST_DOWN;
        else if (lock_done) state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (!pd_eff_n) state_nxt = ST_DOWN;
      end
      // the two-bit encoding leaves one code unused; a flipped state bit
      // lands here and the part falls back to the safe, quiet state
      default: begin
        state_nxt = ST_DOWN;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= ST_DOWN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // lock counter, cleared whenever the part is down
  lock_timer #(
    .COUNT (LOCK_COUNT),
    .W     (LOCK_CNT_W)
  ) u_lock_timer (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .clear_i   (state_r != ST_LOCKING),
    .run_i     (state_r == ST_LOCKING),
    .count_o   (lock_cnt),
    .done_o    (lock_done)
  );

  // ---- output stage ----
  logic up_w;
  logic run_w;
  assign up_w  = (state_r != ST_DOWN);
  assign run_w = (state_r == ST_RUN);

  logic out_p_r;
  logic out_n_r;
  logic oe_r;
  logic pre_r;
  logic term_r;
  logic pll_r;
  logic lock_r;
  logic [RANGE_COUNT-1:0] range_r;

  // output flops; legs held equal while not running so the
  // differential level is zero while termination is in
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_p_r <= 1'b0;
      out_n_r <= 1'b0;
      oe_r    <= 1'b0;
      pre_r   <= 1'b0;
      term_r  <= 1'b0;
      pll_r   <= 1'b0;
      lock_r  <= 1'b0;
      range_r <= '0;
    end else begin
      pll_r   <= (state_nxt != ST_DOWN);
      term_r  <= (state_nxt != ST_DOWN);
      lock_r  <= (state_nxt == ST_RUN);
      oe_r    <= (state_nxt == ST_RUN);
      out_p_r <= (state_nxt == ST_RUN) &  serial_data_i;
      out_n_r <= (state_nxt == ST_RUN) & ~serial_data_i;
      pre_r   <= (state_nxt == ST_RUN) & pre_eff
                 & serial_edge_i;
      range_r <= range_dec;
    end
  end

  assign out_p_o         = out_p_r;
  assign out_n_o         = out_n_r;
  assign out_oe_o        = oe_r;
  assign preemph_pulse_o = pre_r;
  assign term_en_o       = term_r;
  assign pll_run_o       = pll_r;
  assign pll_locked_o    = lock_r;
  assign range_onehot_o  = range_r;
  // data capture only while the pll is up, on this same clock
  assign sample_en_o     = up_w;

  // ---- register port ----
  logic [31:0] rdata_r;
  logic [31:0] rd_mux;
  logic        wr_ctrl;
  logic [31:0] status_w;

  assign wr_ctrl  = wr_i && (addr_i == ADDR_CTRL);
  assign status_w = {22'h0, range_code, preemph_en_i, input_buffer_supply_i,
                     power_down_n_i, oe_r, term_r, lock_r, run_w, up_w};
  // unmapped addresses read as zero
  assign rd_mux = (addr_i == ADDR_CTRL)    ? {30'h0, ctrl_ovr_r, ctrl_pre_r} :
                  (addr_i == ADDR_STATUS)  ? status_w :
                  (addr_i == ADDR_LOCKCNT) ? {17'h0, lock_cnt} : 32'h0;

  // control register write
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_pre_r <= CTRL_RESET[CTRL_PRE_BIT];
      ctrl_ovr_r <= CTRL_RESET[CTRL_PRE_OVR];
    end else if (wr_ctrl) begin
      ctrl_pre_r <= wdata_i[CTRL_PRE_BIT];
      ctrl_ovr_r <= wdata_i[CTRL_PRE_OVR];
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_r <= 32'h0;
    end else begin
      rdata_r <= rd_i ? rd_mux : 32'h0;
    end
  end
  assign rdata_o = rdata_r;

  // ---- assertions ----
  a_down_quiet: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !pd_eff_n |=> !out_oe_o && !term_en_o && !pll_run_o)
    else $error("output active after power-down");
  a_release_term: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (state_r == ST_DOWN && pd_eff_n) |=> term_en_o && pll_run_o)
    else $error("termination not switched in on release");
  a_locking_zero: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (term_en_o && !pll_locked_o) |-> !out_oe_o && (out_p_o == out_n_o))
    else $error("output driven while locking");
  a_lock_time: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $rose(pll_locked_o) |-> lock_cnt == LOCK_CNT_W'(LOCK_COUNT))
    else $error("lock declared at wrong count");
  a_supply_loss: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !input_buffer_supply_i |=> state_r == ST_DOWN)
    else $error("no power-down on input supply loss");
  a_preemph_off: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (!pre_eff) |=> !preemph_pulse_o)
    else $error("preemphasis while disabled");
  a_range_map: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    1'b1 |=> range_onehot_o == RANGE_COUNT'(1) << $past(range_code))
    else $error("range decode wrong");
  a_count_clear: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $rose(term_en_o) |-> lock_cnt <= LOCK_CNT_W'(1))
    else $error("lock count not restarted");

  // once locked the output must be driven with termination still in
  a_lock_drive: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    pll_locked_o |-> out_oe_o && term_en_o)
    else $error("locked but output not driven");

  // a driven output always shows opposite legs, never a shorted pair
  a_run_legs: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    out_oe_o |-> (out_p_o != out_n_o))
    else $error("driven legs not complementary");

  // an aborted lock leaves a cleared counter two edges after the drop is sampled,
  // so a quick re-release cannot inherit a partial count
  a_abort_clear: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (state_r == ST_LOCKING && !pd_eff_n) |-> ##2 lock_cnt == LOCK_CNT_W'(0))
    else $error("aborted lock count not cleared");

  // data capture enable and pll run track the same state
  a_sample_up: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sample_en_o == pll_run_o)
    else $error("capture enable out of step with pll");

  // with the input supply gone the range pins read as the lowest band
  a_range_supply: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !input_buffer_supply_i |=> range_onehot_o == RANGE_COUNT'(1))
    else $error("range pins not ignored without supply");

  c_lock: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $rose(pll_locked_o));
  c_abort: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    state_r == ST_LOCKING ##1 state_r == ST_DOWN);
  c_pre: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    preemph_pulse_o);
  // supply loss while up, the path that forces the part down
  c_supply_drop: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    state_r != ST_DOWN ##1 !input_buffer_supply_i);
  // fastest band selected
  c_range_top: cover property (@(posedge clk_sys_i) disable iff (!rstn_i)
    range_onehot_o[3]);

endmodule : ser_power_ctrl

// ---- dv/host_model.sv ----
// host that drives the serializer power, range and preemphasis pins
`timescale 1ns/1ps
module host_model #(
  parameter int unsigned WAIT = 8  // lock interval in parallel clocks
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rstn_i,
  input  wire logic       up_req_i,  // bench wants the link up
  input  wire logic [1:0] range_i,   // wanted range code
  input  wire logic       pre_i,     // wanted preemphasis
  output logic            power_down_n_o,
  output logic            freq_range_sel_lo_o,
  output logic            freq_range_sel_hi_o,
  output logic            preemph_o,
  output logic            deser_up_o // deserializer released
);
  logic [15:0] wait_r;  // cycles since serializer release

  // range moves only while down, so the clock band never shifts mid-lock
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      power_down_n_o <= 1'b0;
      {freq_range_sel_hi_o, freq_range_sel_lo_o} <= 2'h0;
      preemph_o <= 1'b0;
      wait_r <= 16'h0;
      deser_up_o <= 1'b0;
    end else begin
      power_down_n_o <= up_req_i;
      preemph_o <= pre_i;
      if (!up_req_i) begin
        {freq_range_sel_hi_o, freq_range_sel_lo_o}
          <= range_i;
        wait_r <= 16'h0;
        deser_up_o <= 1'b0;
      end else if (wait_r < 16'(WAIT)) begin
        wait_r <= wait_r + 16'h1;
      end else begin
        deser_up_o <= 1'b1;
      end
    end
  end
endmodule : host_model

// ---- dv/testbench.sv ----
// self-checking bench for the serializer power and lock control
`timescale 1ns/1ps
module testbench
  import ser_pwr_pkg::*;
();
  localparam int unsigned LK = 8;  // short lock count keeps runs brief
  logic clk_sys_i = 1'b0, rstn_i = 1'b0, up = 1'b0, pre = 1'b0;
  logic sup = 1'b1, sd = 1'b0, se = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [1:0]  rng = 2'h0;
  logic [3:0]  addr = 4'h0, oh;
  logic [31:0] wd = 32'h0, rdat, d;
  logic pd_n, rlo, rhi, pin_pre, deser, run, lkd, term, op, on, oe, pp, se_o;
  int failures = 0, cmp_count = 0, n;

  always #2 clk_sys_i = ~clk_sys_i;

  host_model #(.WAIT(LK)) host (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .up_req_i(up), .range_i(rng), .pre_i(pre), .power_down_n_o(pd_n),
    .freq_range_sel_lo_o(rlo), .freq_range_sel_hi_o(rhi),
    .preemph_o(pin_pre), .deser_up_o(deser));

  ser_power_ctrl #(.LOCK_COUNT(LK)) dut (.clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i), .power_down_n_i(pd_n), .freq_range_sel_lo_i(rlo),
    .freq_range_sel_hi_i(rhi), .preemph_en_i(pin_pre),
    .input_buffer_supply_i(sup), .serial_data_i(sd), .serial_edge_i(se),
    .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat),
    .pll_run_o(run), .pll_locked_o(lkd), .term_en_o(term), .out_p_o(op),
    .out_n_o(on), .out_oe_o(oe), .preemph_pulse_o(pp),
    .range_onehot_o(oh), .sample_en_o(se_o));

  task automatic check(input string w, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", w, e, s);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask : tick

  // one-cycle strobes; read data is taken in the cycle after the strobe
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    addr <= a; wd <= v; wr <= w; rd <= !w;
    @(posedge clk_sys_i);
    wr <= 1'b0; rd <= 1'b0;
    #1 d = rdat;
  endtask : bus

  // counts edges from termination switch-in to lock, watching the legs
  task automatic wait_lock();
    n = 0;
    repeat (10) if (term !== 1'b1) tick(1);
    while (lkd !== 1'b1 && n < 40) begin
      check("oe_locking", oe, 0);
      check("legs_equal", op ^ on, 0);
      tick(1);
      n++;
    end
    check("lock_cycles", n, LK + 1);
  endtask : wait_lock

  task automatic pulse(input logic e);
    @(posedge clk_sys_i) se <= 1'b1;
    @(posedge clk_sys_i) se <= 1'b0;
    #1 check("pre_pulse", pp, e);
  endtask : pulse

  task automatic t_down();
    for (int c = 0; c < 4; c++) begin
      @(posedge clk_sys_i) rng <= 2'(c);
      tick(3);
      check("range", oh, 4'h1 << c);
    end
    check("down", {run, term, oe, se_o, op, on}, 0);
    $display("done down");
  endtask : t_down

  task automatic t_lock();
    @(posedge clk_sys_i) begin up <= 1'b1; pre <= 1'b1; end
    wait_lock();
    check("up", {run, term, oe, se_o}, 4'hf);
    @(posedge clk_sys_i) sd <= 1'b1;
    tick(2);
    check("legs", {op, on}, 2'h2);
    pulse(1'b1);
    @(posedge clk_sys_i) pre <= 1'b0;
    tick(3);
    pulse(1'b0);
    bus(1'b1, ADDR_CTRL, 32'h3);  // register override of the pin
    bus(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl", d, 32'h3);
    pulse(1'b1);
    bus(1'b1, ADDR_CTRL, 32'h0);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("status", d[9:0], 10'h37f);
    bus(1'b0, 4'hc, 32'h0);  // unmapped place reads zero
    check("unmapped", d, 0);
    $display("done lock");
  endtask : t_lock

  task automatic t_abort();
    @(posedge clk_sys_i) up <= 1'b0;
    tick(3);
    check("off", {run, term, oe, op, on}, 0);
    @(posedge clk_sys_i) up <= 1'b1;
    tick(6);
    @(posedge clk_sys_i) up <= 1'b0;  // abort mid-count
    tick(4);
    check("abort", lkd, 0);
    @(posedge clk_sys_i) up <= 1'b1;
    wait_lock();
    @(posedge clk_sys_i) sup <= 1'b0;
    tick(3);
    check("no_supply", {run, term, oe, oh}, 4'h1);
    @(posedge clk_sys_i) sup <= 1'b1;
    wait_lock();
    $display("done abort");
  endtask : t_abort

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // tests take about a hundred cycles; 3000 means a hang
  initial begin
    #12000;
    failures++;
    print_verdict();
  end

  initial begin
    repeat (8) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    tick(2);
    t_down();
    t_lock();
    t_abort();
    print_verdict();
  end
endmodule : testbench
